// ==== bench/tb_tcr_timer_regs.sv ====
`timescale 1ns/1ps
module tb_tcr_timer_regs;
  // ---------------------------------------------------------------
  // Harness
  // ---------------------------------------------------------------
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic t3_pin = 1'b0;
  tcr_pkg::tcr_bus_req_t req;
  logic [7:0] rdata;
  logic rvalid;
  logic [1:0][15:0] cnt;
  logic [1:0][2:0] match;
  int error_cnt = 0;
  int total_checks = 0;
  int hits;
  logic [7:0] d;
  bit ok;
  logic [7:0] rst_map [11] = '{8'h48, 8'h49, 8'h4a, 8'h4b, 8'h4c, 8'h4d,
                               8'h78, 8'h79, 8'h86, 8'h88, 8'h89};
  int divs [6] = '{0, 1, 8, 64, 256, 1024};

  always #10 sys_clk_in = ~sys_clk_in;

  tcr_timer_regs #(.CNT_W(16)) u_dut (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .bus_req_in(req),
    .rd_data_out(rdata),
    .rd_valid_out(rvalid),
    .t1_pin_in(1'b0),
    .t3_pin_in(t3_pin),
    .counter_value_out(cnt),
    .compare_match_out(match)
  );

  tcr_cpu_model u_cpu (
    .sys_clk_in(sys_clk_in),
    .rd_data_in(rdata),
    .rd_valid_in(rvalid),
    .bus_req_out(req)
  );

  task automatic give_verdict;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic io, input logic [7:0] a,
                        input logic [7:0] exp);
    u_cpu.rd(io, a, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("Error %0t: no read answer", $time);
      give_verdict();
    end
    check8(d, exp);
  endtask

  task automatic check_cnt(input int t, input logic [15:0] lo,
                           input logic [15:0] hi);
    total_checks++;
    if ((cnt[t] >= lo && cnt[t] <= hi) !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: counter %0d is %h", $time, t, cnt[t]);
    end
  endtask

  task automatic count_match(input int n);
    hits = 0;
    repeat (n) begin
      @(posedge sys_clk_in);
      #1;
      if (match[0][0] === 1'b1) hits++;
    end
  endtask

  task automatic pin_set(input logic v);
    @(posedge sys_clk_in);
    #1;
    t3_pin = v;
    repeat (3) @(posedge sys_clk_in);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk_in);
    #1;
    resetn_in = 1'b1;
    foreach (rst_map[i]) rd_chk(1'b0, rst_map[i], 8'h00);
    // Compare A written through its I/O form
    u_cpu.wr(1'b1, 8'h2b, 8'h12);
    u_cpu.wr(1'b1, 8'h2a, 8'h34);
    rd_chk(1'b0, 8'h4a, 8'h34);
    rd_chk(1'b0, 8'h4b, 8'h12);
    // High byte staged by one register, committed by another
    u_cpu.wr(1'b0, 8'h87, 8'hab);
    u_cpu.wr(1'b0, 8'h78, 8'hcd);
    rd_chk(1'b0, 8'h79, 8'hab);
    rd_chk(1'b0, 8'h87, 8'h00);
    // I/O forms cannot reach extended locations
    u_cpu.wr(1'b1, 8'h66, 8'h55);
    rd_chk(1'b0, 8'h86, 8'h00);
    rd_chk(1'b1, 8'h58, 8'h00);
    // Timer 3 on pin edges; high byte frozen by the low read
    u_cpu.wr(1'b0, 8'h8a, 8'h07);
    u_cpu.wr(1'b0, 8'h89, 8'h12);
    u_cpu.wr(1'b0, 8'h88, 8'hff);
    rd_chk(1'b0, 8'h88, 8'hff);
    pin_set(1'b1);
    rd_chk(1'b0, 8'h89, 8'h12);
    check_cnt(1, 16'h1300, 16'h1300);
    u_cpu.wr(1'b0, 8'h8a, 8'h06);
    pin_set(1'b0);
    check_cnt(1, 16'h1301, 16'h1301);
    u_cpu.wr(1'b0, 8'h8a, 8'h00);
    pin_set(1'b1);
    pin_set(1'b0);
    check_cnt(1, 16'h1301, 16'h1301);
    // Timer 1 through each prescaler tap
    for (int c = 1; c <= 5; c++) begin
      u_cpu.wr(1'b0, 8'h4e, 8'(c));
      u_cpu.wr(1'b0, 8'h4d, 8'h00);
      u_cpu.wr(1'b0, 8'h4c, 8'h00);
      repeat (4 * divs[c]) @(posedge sys_clk_in);
      #1;
      check_cnt(0, 16'h0003, 16'h0006);
    end
    // Match seen normally, then lost after a counter write
    u_cpu.wr(1'b0, 8'h4e, 8'h01);
    u_cpu.wr(1'b0, 8'h4b, 8'h00);
    u_cpu.wr(1'b0, 8'h4a, 8'h40);
    u_cpu.wr(1'b0, 8'h4c, 8'h30);
    count_match(40);
    check8(8'(hits), 8'h01);
    u_cpu.wr(1'b0, 8'h4c, 8'h40);
    count_match(10);
    check8(8'(hits), 8'h00);
    give_verdict();
  end
endmodule

// ==== bench/tcr_cpu_model.sv ====
`timescale 1ns/1ps
module tcr_cpu_model (
  input wire logic sys_clk_in,
  input wire logic [7:0] rd_data_in,
  input wire logic rd_valid_in,
  output tcr_pkg::tcr_bus_req_t bus_req_out
);
  // ---------------------------------------------------------------
  // Core-side access: one-cycle strobes, released lines scrambled
  // ---------------------------------------------------------------
  initial bus_req_out = '0;

  task automatic issue(input logic w, input logic io, input logic [7:0] a,
                       input logic [7:0] d);
    @(posedge sys_clk_in);
    #1;
    bus_req_out = '{wr: w, rd: !w, io_space: io,
                    addr: a, wdata: d};
    @(posedge sys_clk_in);
    #1;
    bus_req_out = '{wr: 1'b0, rd: 1'b0, io_space: !io, addr: ~a, wdata: ~d};
  endtask

  task automatic wr(input logic io, input logic [7:0] a, input logic [7:0] d);
    issue(1'b1, io, a, d);
  endtask

  task automatic rd(input logic io, input logic [7:0] a,
                    output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    issue(1'b0, io, a, 8'h00);
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge sys_clk_in);
      #1;
      if (rd_valid_in === 1'b1) begin
        ok = 1'b1;
        d = rd_data_in;
      end
    end
  endtask
endmodule

// ==== bench/tcr_timer_regs_chk.sv ====
`timescale 1ns/1ps
module tcr_timer_regs_chk #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire tcr_pkg::tcr_bus_req_t bus_req_in,
  input wire logic [7:0] rd_data_out,
  input wire logic rd_valid_out,
  input wire logic t1_pin_in,
  input wire logic t3_pin_in,
  input wire logic [tcr_pkg::TIMERS-1:0][CNT_W-1:0] counter_value_out,
  input wire logic [tcr_pkg::TIMERS-1:0][tcr_pkg::CHANNELS-1:0]
    compare_match_out
);
  // ---------------------------------------------------------------
  // Request decode in data-space terms
  // ---------------------------------------------------------------
  logic [7:0] da;
  logic wr1;
  logic wr3;
  logic cw1;

  default clocking @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  assign da = !bus_req_in.io_space ? bus_req_in.addr :
    (bus_req_in.addr < tcr_pkg::IO_LIMIT) ?
    bus_req_in.addr + tcr_pkg::IO_TO_DATA : 8'hff;
  assign wr1 = bus_req_in.wr && da == 8'h4c;
  assign wr3 = bus_req_in.wr && da == tcr_pkg::T3_COUNT_LOW;
  assign cw1 = bus_req_in.wr && (da == 8'h4c || da == 8'h4d);

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  a_rd_answer: assert property (
    bus_req_in.rd |-> ##2 rd_valid_out)
    else $error("read not answered two cycles later");
  a_valid_cause: assert property (
    rd_valid_out |-> $past(bus_req_in.rd, 2))
    else $error("read answer without a read");
  a_data_holds: assert property (
    !rd_valid_out |-> $stable(rd_data_out))
    else $error("read data moved without an answer");
  a_io_limit: assert property (
    bus_req_in.rd && bus_req_in.io_space &&
    bus_req_in.addr >= tcr_pkg::IO_LIMIT |-> ##2 rd_data_out == 8'h00)
    else $error("I/O form beyond its range returned data");
  a_t1_low_wr: assert property (
    wr1 |=> counter_value_out[0][7:0] == $past(bus_req_in.wdata))
    else $error("timer 1 low byte write not applied");
  a_t3_low_wr: assert property (
    wr3 |=> counter_value_out[1][7:0] == $past(bus_req_in.wdata))
    else $error("timer 3 low byte write not applied");
  a_write_blocks: assert property (
    cw1 |-> ##2 compare_match_out[0] == 3'h0)
    else $error("match after a counter write");
  a_count_step: assert property (
    !$past(bus_req_in.wr) |->
    CNT_W'(counter_value_out[0] - $past(counter_value_out[0])) <= 1 &&
    CNT_W'(counter_value_out[1] - $past(counter_value_out[1])) <= 1)
    else $error("counter moved by more than one");
  a_match_pulse: assert property (
    (compare_match_out & $past(compare_match_out)) == '0)
    else $error("match pulse longer than one cycle");
endmodule

bind tcr_timer_regs tcr_timer_regs_chk #(.CNT_W(CNT_W)) u_chk (
  .sys_clk_in(sys_clk_in),
  .resetn_in(resetn_in),
  .bus_req_in(bus_req_in),
  .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out),
  .t1_pin_in(t1_pin_in),
  .t3_pin_in(t3_pin_in),
  .counter_value_out(counter_value_out),
  .compare_match_out(compare_match_out)
);

// ==== design/tcr_cmp_store.sv ====
`timescale 1ns/1ps
module tcr_cmp_store #(
  parameter int WORDS = 6,
  parameter int WIDTH = 16,
  parameter int IDX_W = 3
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [WIDTH-1:0] wr_data_in,
  input wire logic [IDX_W-1:0] rd_idx_in,
  output logic [WIDTH-1:0] rd_data_out,
  output logic [WORDS-1:0][WIDTH-1:0] words_out
);

  // ---------------------------------------------------------------
  // Storage, with every word also visible to the comparators
  // ---------------------------------------------------------------
  logic [WORDS-1:0][WIDTH-1:0] mem_q;
  logic [WIDTH-1:0] rd_q;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_q <= '0;
    end else if (wr_en_in && (int'(wr_idx_in) < WORDS)) begin
      mem_q[wr_idx_in] <= wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_q <= '0;
    end else if (int'(rd_idx_in) < WORDS) begin
      rd_q <= mem_q[rd_idx_in];
    end else begin
      rd_q <= '0;
    end
  end

  assign rd_data_out = rd_q;
  assign words_out = mem_q;

endmodule

// ==== design/tcr_pkg.sv ====
package tcr_pkg;

  // ---------------------------------------------------------------
  // Address map
  // ---------------------------------------------------------------
  // Low I/O locations are given by I/O offset; data space adds 0x20
  localparam logic [7:0] IO_TO_DATA = 8'h20;
  localparam logic [7:0] IO_LIMIT = 8'h40;
  localparam logic [7:0] T1_COMPARE_B_LOW = 8'h28;
  localparam logic [7:0] T1_COMPARE_B_HIGH = 8'h29;
  localparam logic [7:0] T1_COMPARE_A_LOW = 8'h2a;
  localparam logic [7:0] T1_COMPARE_A_HIGH = 8'h2b;
  localparam logic [7:0] T1_COUNT_LOW = 8'h2c;
  localparam logic [7:0] T1_COUNT_HIGH = 8'h2d;
  localparam logic [7:0] T1_CONTROL_B = 8'h2e;
  // Extended I/O locations are data-space addresses
  localparam logic [7:0] T1_COMPARE_C_LOW = 8'h78;
  localparam logic [7:0] T1_COMPARE_C_HIGH = 8'h79;
  localparam logic [7:0] T3_COMPARE_C_LOW = 8'h82;
  localparam logic [7:0] T3_COMPARE_C_HIGH = 8'h83;
  localparam logic [7:0] T3_COMPARE_B_LOW = 8'h84;
  localparam logic [7:0] T3_COMPARE_B_HIGH = 8'h85;
  localparam logic [7:0] T3_COMPARE_A_LOW = 8'h86;
  localparam logic [7:0] T3_COMPARE_A_HIGH = 8'h87;
  localparam logic [7:0] T3_COUNT_LOW = 8'h88;
  localparam logic [7:0] T3_COUNT_HIGH = 8'h89;
  localparam logic [7:0] T3_CONTROL_B = 8'h8a;

  // ---------------------------------------------------------------
  // Fields, reset values, clock select
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [2:0] CS_RESET = 3'h0;
  localparam logic [4:0] CTRL_PAD = 5'h00;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_PIN_FALL = 3'h6;
  localparam logic [2:0] CS_PIN_RISE = 3'h7;
  localparam int PRESCALE_W = 10;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
  localparam int TIMERS = 2;
  localparam int CHANNELS = 3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    kind_none,
    kind_count,
    kind_compare,
    kind_control
  } tcr_kind_t;

  typedef struct packed {
    tcr_kind_t kind;
    logic timer;
    logic [1:0] channel;
    logic high;
  } tcr_sel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcr_bus_req_t;

endpackage

// ==== design/tcr_timer_regs.sv ====
`timescale 1ns/1ps
// Behaviour
// - The counter low byte reads and writes the live count; the high byte goes through the holding register.
// - 16-bit accesses stay atomic through an 8-bit holding register.
// - One holding register serves every 16-bit register of both timers.
// - A counter write blocks the next timer clock's matches on all channels.
// - Each low I/O register is also decoded in data space at offset + 0x20.
// - A 3-bit code selects stop, /1, /8, /64, /256, /1024 or a pin edge.
module tcr_timer_regs #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire tcr_pkg::tcr_bus_req_t bus_req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  input wire logic t1_pin_in,
  input wire logic t3_pin_in,
  output logic [tcr_pkg::TIMERS-1:0][CNT_W-1:0] counter_value_out,
  output logic [tcr_pkg::TIMERS-1:0][tcr_pkg::CHANNELS-1:0]
    compare_match_out
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic tcr_pkg::tcr_sel_t decode(input logic [7:0] a);
    tcr_pkg::tcr_sel_t s;
    s.kind = tcr_pkg::kind_none;
    s.timer = 1'b0;
    s.channel = 2'h0;
    s.high = 1'b0;
    if (a == tcr_pkg::T1_COUNT_LOW + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_count;
    end else if (a == tcr_pkg::T1_COUNT_HIGH + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_count;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T1_COMPARE_A_LOW + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_compare;
    end else if (a == tcr_pkg::T1_COMPARE_A_HIGH + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_compare;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T1_COMPARE_B_LOW + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_compare;
      s.channel = 2'h1;
    end else if (a == tcr_pkg::T1_COMPARE_B_HIGH + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_compare;
      s.channel = 2'h1;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T1_CONTROL_B + tcr_pkg::IO_TO_DATA) begin
      s.kind = tcr_pkg::kind_control;
    end else if (a == tcr_pkg::T1_COMPARE_C_LOW) begin
      s.kind = tcr_pkg::kind_compare;
      s.channel = 2'h2;
    end else if (a == tcr_pkg::T1_COMPARE_C_HIGH) begin
      s.kind = tcr_pkg::kind_compare;
      s.channel = 2'h2;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T3_COUNT_LOW) begin
      s.kind = tcr_pkg::kind_count;
      s.timer = 1'b1;
    end else if (a == tcr_pkg::T3_COUNT_HIGH) begin
      s.kind = tcr_pkg::kind_count;
      s.timer = 1'b1;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T3_COMPARE_A_LOW) begin
      s.kind = tcr_pkg::kind_compare;
      s.timer = 1'b1;
    end else if (a == tcr_pkg::T3_COMPARE_A_HIGH) begin
      s.kind = tcr_pkg::kind_compare;
      s.timer = 1'b1;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T3_COMPARE_B_LOW) begin
      s.kind = tcr_pkg::kind_compare;
      s.timer = 1'b1;
      s.channel = 2'h1;
    end else if (a == tcr_pkg::T3_COMPARE_B_HIGH) begin
      s.kind = tcr_pkg::kind_compare;
      s.timer = 1'b1;
      s.channel = 2'h1;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T3_COMPARE_C_LOW) begin
      s.kind = tcr_pkg::kind_compare;
      s.timer = 1'b1;
      s.channel = 2'h2;
    end else if (a == tcr_pkg::T3_COMPARE_C_HIGH) begin
      s.kind = tcr_pkg::kind_compare;
      s.timer = 1'b1;
      s.channel = 2'h2;
      s.high = 1'b1;
    end else if (a == tcr_pkg::T3_CONTROL_B) begin
      s.kind = tcr_pkg::kind_control;
      s.timer = 1'b1;
    end
    return s;
  endfunction

  function automatic logic clock_tick(input logic [2:0] code,
                                      input logic [9:0] pre,
                                      input logic pin,
                                      input logic pin_prev);
    logic t;
    t = 1'b0;
    case (code)
      tcr_pkg::CS_STOP: t = 1'b0;
      tcr_pkg::CS_DIV1: t = 1'b1;
      tcr_pkg::CS_DIV8: t = &(pre | ~tcr_pkg::MASK_DIV8);
      tcr_pkg::CS_DIV64: t = &(pre | ~tcr_pkg::MASK_DIV64);
      tcr_pkg::CS_DIV256: t = &(pre | ~tcr_pkg::MASK_DIV256);
      tcr_pkg::CS_DIV1024: t = &(pre | ~tcr_pkg::MASK_DIV1024);
      tcr_pkg::CS_PIN_FALL: t = pin_prev && !pin;
      tcr_pkg::CS_PIN_RISE: t = !pin_prev && pin;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic [2:0] word_index(input logic timer,
                                            input logic [1:0] channel);
    return timer ? 3'(channel) + 3'(tcr_pkg::CHANNELS) : 3'(channel);
  endfunction

  // ---------------------------------------------------------------
  // Request decode
  // ---------------------------------------------------------------
  logic [7:0] data_addr;
  tcr_pkg::tcr_sel_t sel;
  logic wr_count_low;
  logic [7:0] temp_q;
  logic [tcr_pkg::TIMERS-1:0][CNT_W-1:0] count_q;
  logic [tcr_pkg::TIMERS-1:0][2:0] cs_q;
  logic [tcr_pkg::TIMERS-1:0] block_q;
  logic [tcr_pkg::TIMERS-1:0] tick;
  logic [tcr_pkg::TIMERS-1:0] pin_now;
  logic [tcr_pkg::TIMERS-1:0] pin_prev_q;
  logic [tcr_pkg::PRESCALE_W-1:0] pre_q;
  logic [5:0][CNT_W-1:0] cmp_words;
  logic [CNT_W-1:0] cmp_rd;
  logic cmp_wr;
  logic rd_pend_q;
  tcr_pkg::tcr_sel_t rd_sel_q;
  logic [7:0] rd_byte_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  logic [tcr_pkg::TIMERS-1:0][tcr_pkg::CHANNELS-1:0] match_q;

  // I/O-form addresses cover 64 locations and map 0x20 up into data space
  always_comb begin
    if (bus_req_in.io_space && (bus_req_in.addr < tcr_pkg::IO_LIMIT)) begin
      data_addr = bus_req_in.addr + tcr_pkg::IO_TO_DATA;
    end else if (bus_req_in.io_space) begin
      data_addr = tcr_pkg::BYTE_RESET;
    end else begin
      data_addr = bus_req_in.addr;
    end
  end

  assign sel = decode(data_addr);
  assign wr_count_low = bus_req_in.wr && (sel.kind == tcr_pkg::kind_count)
                        && !sel.high;
  assign cmp_wr = bus_req_in.wr && (sel.kind == tcr_pkg::kind_compare)
                  && !sel.high;

  // ---------------------------------------------------------------
  // Shared high-byte holding register
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      temp_q <= tcr_pkg::BYTE_RESET;
    end else if (bus_req_in.wr && sel.high &&
                 (sel.kind != tcr_pkg::kind_none)) begin
      temp_q <= bus_req_in.wdata;
    end else if (bus_req_in.rd && (sel.kind == tcr_pkg::kind_count) &&
                 !sel.high) begin
      temp_q <= count_q[sel.timer][15:8];
    end
  end

  // ---------------------------------------------------------------
  // Clock select and prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cs_q <= '0;
    end else if (bus_req_in.wr && (sel.kind == tcr_pkg::kind_control)) begin
      cs_q[sel.timer] <= bus_req_in.wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_q <= '0;
      pin_prev_q <= '0;
    end else begin
      pre_q <= pre_q + 10'h001;
      pin_prev_q <= pin_now;
    end
  end

  assign pin_now = {t3_pin_in, t1_pin_in};

  always_comb begin
    for (int t = 0; t < tcr_pkg::TIMERS; t++) begin
      tick[t] = clock_tick(cs_q[t], pre_q, pin_now[t], pin_prev_q[t]);
    end
  end

  // ---------------------------------------------------------------
  // Counters and match blocking
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else begin
      for (int t = 0; t < tcr_pkg::TIMERS; t++) begin
        if (wr_count_low && (int'(sel.timer) == t)) begin
          count_q[t] <= {temp_q, bus_req_in.wdata};
        end else if (tick[t]) begin
          count_q[t] <= count_q[t] + 16'h0001;
        end
      end
    end
  end

  // A counter write arms the block; the next timer clock consumes it
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      block_q <= '0;
    end else begin
      for (int t = 0; t < tcr_pkg::TIMERS; t++) begin
        if (bus_req_in.wr && (sel.kind == tcr_pkg::kind_count) &&
            (int'(sel.timer) == t)) begin
          block_q[t] <= 1'b1;
        end else if (tick[t]) begin
          block_q[t] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      match_q <= '0;
    end else begin
      for (int t = 0; t < tcr_pkg::TIMERS; t++) begin
        for (int c = 0; c < tcr_pkg::CHANNELS; c++) begin
          match_q[t][c] <= tick[t] && !block_q[t] &&
            (count_q[t] == cmp_words[t * tcr_pkg::CHANNELS + c]);
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Compare value store
  // ---------------------------------------------------------------
  tcr_cmp_store #(
    .WORDS(tcr_pkg::TIMERS * tcr_pkg::CHANNELS),
    .WIDTH(CNT_W),
    .IDX_W(3)
  ) u_store (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_en_in(cmp_wr),
    .wr_idx_in(word_index(sel.timer, sel.channel)),
    .wr_data_in({temp_q, bus_req_in.wdata}),
    .rd_idx_in(word_index(sel.timer, sel.channel)),
    .rd_data_out(cmp_rd),
    .words_out(cmp_words)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_pend_q <= 1'b0;
      rd_sel_q <= '0;
      rd_byte_q <= tcr_pkg::BYTE_RESET;
    end else begin
      rd_pend_q <= bus_req_in.rd;
      rd_sel_q <= sel;
      if (sel.kind == tcr_pkg::kind_count && sel.high) begin
        rd_byte_q <= temp_q;
      end else if (sel.kind == tcr_pkg::kind_count) begin
        rd_byte_q <= count_q[sel.timer][7:0];
      end else if (sel.kind == tcr_pkg::kind_control) begin
        rd_byte_q <= {tcr_pkg::CTRL_PAD, cs_q[sel.timer]};
      end else begin
        rd_byte_q <= tcr_pkg::BYTE_RESET;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_q <= tcr_pkg::BYTE_RESET;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_pend_q;
      if (rd_pend_q && rd_sel_q.kind == tcr_pkg::kind_compare) begin
        rd_data_q <= rd_sel_q.high ? cmp_rd[15:8] : cmp_rd[7:0];
      end else if (rd_pend_q) begin
        rd_data_q <= rd_byte_q;
      end
    end
  end

  assign rd_data_out = rd_data_q;
  assign rd_valid_out = rd_valid_q;
  assign counter_value_out = count_q;
  assign compare_match_out = match_q;

endmodule
